// File: rtl/cpuc_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef CPUC_REGS_VH
`define CPUC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CPUC_REG_SRC_CTRL    8'h00
`define CPUC_REG_PWR_CTRL    8'h01
`define CPUC_REG_WDOG_CTRL   8'h05
`define CPUC_REG_MISC_CTRL   8'h07
`define CPUC_REG_SYS_STAT    8'h08
`define CPUC_REG_IRQ_STAT    8'h0A
`define CPUC_REG_IRQ_MASK    8'h0B

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CPUC_HIZ_BIT         7
`define CPUC_ILIM_MSB        2
`define CPUC_REG_RESET_BIT   7
`define CPUC_WDOG_MSB        5
`define CPUC_WDOG_LSB        4
`define CPUC_FORCE_DET_BIT   7
`define CPUC_SW_OFF_BIT      5
`define CPUC_SRC_TYPE_MSB    7
`define CPUC_SRC_TYPE_LSB    6
`define CPUC_PG_BIT          2

// Interrupt status and mask bits
`define CPUC_IRQ_PG          0
`define CPUC_IRQ_DET_DONE    1
`define CPUC_IRQ_POOR_SRC    2
`define CPUC_IRQ_SW_ON       3

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define CPUC_ILIM_100MA      3'h0
`define CPUC_ILIM_500MA      3'h2
`define CPUC_ILIM_RST        3'h0
`define CPUC_WDOG_RST        2'h1
`define CPUC_WDOG_OFF        2'h0
`define CPUC_SRC_USB_HOST    2'h1
`define CPUC_SRC_NONE        2'h0
`define CPUC_IRQ_MASK_RST    4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CPUC_CLK_HZ          50000000
`define CPUC_CYC_PER_MS      (`CPUC_CLK_HZ / 1000)
`define CPUC_T_BIAS_MS       220
`define CPUC_T_RETRY_MS      2000
`define CPUC_T_BADSRC_MS     30
`define CPUC_T_WAKE_MS       2
`define CPUC_DET_CYC         16

`endif

// File: rtl/cpuc_sync.v
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns

module cpuc_sync #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         rst_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;

endmodule // cpuc_sync

// File: rtl/cpuc_top.v
// Charger power-up, source qualification and input current limit control
// ----------------------------------------------------------------------
// How it works
// - First supply or battery release, with neither up before, resets all registers
// - Battery only: switch on, bias regulator off
// - Off bit forces battery switch off
// - Five wake events re-enable switch, clear bit
// - Bias regulator after conditions plus delay
// - Otherwise high-impedance state, regulator off
// - Buck needs no overvoltage, passes load test
// - Qualified source: status, pin, interrupt
// - Failed poor-source test retries every 2 s
// - Detect limit each insertion unless host HIGH_IMPEDANCE_STATE
// - Detection writes source type; limit only if port-type high
// - Host may overwrite limit; device applies
// - Port-type high: 100/500 mA, type 01
// ----------------------------------------------------------------------
`timescale 1ns/1ns
`include "cpuc_regs.vh"

module cpuc_top #(
   parameter [26:0] BIAS_DLY_CYC   = `CPUC_T_BIAS_MS * `CPUC_CYC_PER_MS,
   parameter [26:0] RETRY_CYC      = `CPUC_T_RETRY_MS * `CPUC_CYC_PER_MS,
   parameter [26:0] BADSRC_CYC     = `CPUC_T_BADSRC_MS * `CPUC_CYC_PER_MS,
   parameter [26:0] WAKE_CYC       = `CPUC_T_WAKE_MS * `CPUC_CYC_PER_MS
) (
   input  wire       clk_in,
   input  wire       rst_in,
   // Register port
   input  wire [7:0] addr_in,
   input  wire [7:0] wr_data_in,
   input  wire       wr_in,
   input  wire       rd_in,
   output wire [7:0] rd_data_out,
   // Comparator and pin levels, asynchronous
   input  wire       vbus_undervoltage_release_level_in,
   input  wire       bat_undervoltage_release_level_in,
   input  wire       bat_above_depl_in,
   input  wire       vbus_above_sleepz_in,
   input  wire       vbus_below_sleep_in,
   input  wire       boost_mode_in,
   input  wire       vbus_ovp_in,
   input  wire       vbus_above_badsrc_in,
   input  wire       port_type_pin_in,
   input  wire       current_select_pin_in,
   input  wire       wake_pin_in,
   // Watchdog expiry pulse, same clock
   input  wire       wdog_expire_in,
   // Controls and status
   output wire       bias_reg_en_out,
   output wire       battery_switch_on_out,
   output wire       test_load_en_out,
   output wire       buck_en_out,
   output wire       hiz_out,
   output wire [2:0] ilim_applied_out,
   output wire       power_good_pin_n_out,
   output wire       int_out
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [2:0] ST_HIZ    = 3'd0;
   localparam [2:0] ST_DELAY  = 3'd1;
   localparam [2:0] ST_QUAL   = 3'd2;
   localparam [2:0] ST_RETRY  = 3'd3;
   localparam [2:0] ST_DETECT = 3'd4;
   localparam [2:0] ST_GOOD   = 3'd5;

   localparam [26:0] DET_CYC = `CPUC_DET_CYC;

   // ----------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------
   wire [10:0] pins_s;
   wire        vbus_ok_s;
   wire        bat_ok_s;
   wire        bat_depl_s;
   wire        sleepz_s;
   wire        sleep_s;
   wire        boost_s;
   wire        ovp_s;
   wire        badsrc_s;
   wire        port_type_s;
   wire        cur_sel_s;
   wire        wake_s;

   cpuc_sync #(
      .W      (11)
   ) u_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({wake_pin_in, current_select_pin_in, port_type_pin_in,
                vbus_above_badsrc_in, vbus_ovp_in, boost_mode_in,
                vbus_below_sleep_in, vbus_above_sleepz_in, bat_above_depl_in,
                bat_undervoltage_release_level_in, vbus_undervoltage_release_level_in}),
      .q_out  (pins_s)
   );

   assign vbus_ok_s   = pins_s[0];
   assign bat_ok_s    = pins_s[1];
   assign bat_depl_s  = pins_s[2];
   assign sleepz_s    = pins_s[3];
   assign sleep_s     = pins_s[4];
   assign boost_s     = pins_s[5];
   assign ovp_s       = pins_s[6];
   assign badsrc_s    = pins_s[7];
   assign port_type_s = pins_s[8];
   assign cur_sel_s   = pins_s[9];
   assign wake_s      = pins_s[10];

   // ----------------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------------
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [26:0] cnt_q;
   reg  [26:0] cnt_d;
   reg  [26:0] wake_cnt_q;
   reg         wake_arm_q;
   reg         supply_q;
   reg         vbus_ok_q;
   reg         wake_q;
   reg         hiz_bit_q;
   reg  [2:0]  ilim_q;
   reg  [1:0]  wdog_q;
   reg         force_det_q;
   reg         sw_off_q;
   reg  [1:0]  src_type_q;
   reg         pg_q;
   reg  [3:0]  irq_sts_q;
   reg  [3:0]  irq_msk_q;
   reg  [7:0]  rd_data_q;
   reg         int_q;
   reg         bias_en_q;
   reg         sw_on_q;
   reg         load_q;
   reg         buck_q;
   reg  [2:0]  ilim_app_q;
   reg  [3:0]  irq_evt;

   wire        soft_rst;
   wire        bias_cond;
   wire        plug_evt;
   wire        wake_evt;
   wire        wdog_evt;
   wire        sw_clr_evt;
   wire        det_done;
   wire        src_pass;

   function wr_at;
      input [7:0] a;
      begin
         wr_at = wr_in && (addr_in == a);
      end
   endfunction

   function timer_done;
      input [26:0] cnt;
      input [26:0] lim;
      begin
         timer_done = (cnt >= lim - 27'd1);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------------
   // Release of a supply while neither was up starts a fresh register set
   assign soft_rst   = ((vbus_ok_s | bat_ok_s) & ~supply_q)
                     | (wr_at(`CPUC_REG_PWR_CTRL) & wr_data_in[`CPUC_REG_RESET_BIT]);
   assign plug_evt   = vbus_ok_s & ~vbus_ok_q;
   // Expiry only counts while the watchdog is left running
   assign wdog_evt   = wdog_expire_in & (wdog_q != `CPUC_WDOG_OFF);
   assign wake_evt   = wake_arm_q & wake_s & timer_done(wake_cnt_q, WAKE_CYC);
   assign sw_clr_evt = plug_evt | wdog_evt | wake_evt;
   // Regulator conditions; host HIGH_IMPEDANCE_STATE also holds it off
   assign bias_cond  = vbus_ok_s & (boost_s ? sleep_s : sleepz_s) & ~hiz_bit_q;
   assign src_pass   = ~ovp_s & badsrc_s;
   assign det_done   = (state_q == ST_DETECT) && timer_done(cnt_q, DET_CYC);

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         supply_q   <= 1'b0;
         vbus_ok_q  <= 1'b0;
         wake_q     <= 1'b0;
         wake_arm_q <= 1'b0;
         wake_cnt_q <= 27'd0;
      end
      else
      begin
         supply_q  <= vbus_ok_s | bat_ok_s;
         vbus_ok_q <= vbus_ok_s;
         wake_q    <= wake_s;
         // Wake pin must stay high for the whole on-time
         if (wake_s && !wake_q)
         begin
            wake_arm_q <= 1'b1;
            wake_cnt_q <= 27'd0;
         end
         else if (!wake_s || wake_evt)
         begin
            wake_arm_q <= 1'b0;
            wake_cnt_q <= 27'd0;
         end
         else if (wake_arm_q)
         begin
            wake_cnt_q <= wake_cnt_q + 27'd1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Power-up sequence
   // ----------------------------------------------------------------------
   always @*
   begin
      state_d = state_q;
      cnt_d   = cnt_q + 27'd1;
      if (!bias_cond)
      begin
         state_d = ST_HIZ;
         cnt_d   = 27'd0;
      end
      else
      begin
         case (state_q)
            ST_HIZ:
            begin
               state_d = ST_DELAY;
               cnt_d   = 27'd0;
            end
            ST_DELAY:
            begin
               if (timer_done(cnt_q, BIAS_DLY_CYC))
               begin
                  state_d = ST_QUAL;
                  cnt_d   = 27'd0;
               end
            end
            ST_QUAL:
            begin
               if (timer_done(cnt_q, BADSRC_CYC))
               begin
                  state_d = src_pass ? ST_DETECT : ST_RETRY;
                  cnt_d   = 27'd0;
               end
            end
            ST_RETRY:
            begin
               if (timer_done(cnt_q, RETRY_CYC))
               begin
                  state_d = ST_QUAL;
                  cnt_d   = 27'd0;
               end
            end
            ST_DETECT:
            begin
               if (det_done)
               begin
                  state_d = ST_GOOD;
                  cnt_d   = 27'd0;
               end
            end
            ST_GOOD:
            begin
               cnt_d = 27'd0;
               if (force_det_q || wdog_evt)
               begin
                  state_d = ST_DETECT;
               end
            end
            default:
            begin
               state_d = ST_HIZ;
               cnt_d   = 27'd0;
            end
         endcase
      end
   end

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_HIZ;
         cnt_q   <= 27'd0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         hiz_bit_q   <= 1'b0;
         ilim_q      <= `CPUC_ILIM_RST;
         wdog_q      <= `CPUC_WDOG_RST;
         force_det_q <= 1'b0;
         sw_off_q    <= 1'b0;
         src_type_q  <= `CPUC_SRC_NONE;
         pg_q        <= 1'b0;
         irq_msk_q   <= `CPUC_IRQ_MASK_RST;
      end
      else if (soft_rst)
      begin
         hiz_bit_q   <= 1'b0;
         ilim_q      <= `CPUC_ILIM_RST;
         wdog_q      <= `CPUC_WDOG_RST;
         force_det_q <= 1'b0;
         sw_off_q    <= 1'b0;
         src_type_q  <= `CPUC_SRC_NONE;
         pg_q        <= 1'b0;
         irq_msk_q   <= `CPUC_IRQ_MASK_RST;
      end
      else
      begin
         if (wr_at(`CPUC_REG_SRC_CTRL))
            hiz_bit_q <= wr_data_in[`CPUC_HIZ_BIT];
         else if (!vbus_ok_s)
            hiz_bit_q <= 1'b0;
         // A host write overrides a detection result in the same cycle
         if (wr_at(`CPUC_REG_SRC_CTRL))
            ilim_q <= wr_data_in[`CPUC_ILIM_MSB:0];
         else if (det_done && port_type_s)
            ilim_q <= cur_sel_s ? `CPUC_ILIM_500MA : `CPUC_ILIM_100MA;
         if (det_done)
            src_type_q <= port_type_s ? `CPUC_SRC_USB_HOST : `CPUC_SRC_NONE;
         else if (!vbus_ok_s)
            src_type_q <= `CPUC_SRC_NONE;
         if (wr_at(`CPUC_REG_WDOG_CTRL))
            wdog_q <= wr_data_in[`CPUC_WDOG_MSB:`CPUC_WDOG_LSB];
         if (wr_at(`CPUC_REG_MISC_CTRL))
            force_det_q <= wr_data_in[`CPUC_FORCE_DET_BIT];
         else if (det_done)
            force_det_q <= 1'b0;
         if (wr_at(`CPUC_REG_MISC_CTRL))
            sw_off_q <= wr_data_in[`CPUC_SW_OFF_BIT];
         else if (sw_clr_evt)
            sw_off_q <= 1'b0;
         if (state_q == ST_QUAL && state_d == ST_DETECT)
            pg_q <= 1'b1;
         else if (state_d == ST_HIZ)
            pg_q <= 1'b0;
         if (wr_at(`CPUC_REG_IRQ_MASK))
            irq_msk_q <= wr_data_in[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   always @*
   begin
      irq_evt = 4'h0;
      irq_evt[`CPUC_IRQ_PG]       = (state_q == ST_QUAL) && (state_d == ST_DETECT);
      irq_evt[`CPUC_IRQ_DET_DONE] = det_done;
      irq_evt[`CPUC_IRQ_POOR_SRC] = (state_q == ST_QUAL) && (state_d == ST_RETRY);
      irq_evt[`CPUC_IRQ_SW_ON]    = sw_off_q && sw_clr_evt;
   end

   // Set beats a simultaneous write-one clear
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         irq_sts_q <= 4'h0;
         int_q     <= 1'b0;
      end
      else if (soft_rst)
      begin
         irq_sts_q <= 4'h0;
         int_q     <= 1'b0;
      end
      else
      begin
         if (wr_at(`CPUC_REG_IRQ_STAT))
            irq_sts_q <= (irq_sts_q & ~wr_data_in[3:0]) | irq_evt;
         else
            irq_sts_q <= irq_sts_q | irq_evt;
         int_q <= |(irq_sts_q & irq_msk_q);
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         rd_data_q <= 8'h00;
      else if (!rd_in)
         rd_data_q <= 8'h00;
      else if (addr_in == `CPUC_REG_SRC_CTRL)
         rd_data_q <= {hiz_bit_q, 4'h0, ilim_q};
      else if (addr_in == `CPUC_REG_WDOG_CTRL)
         rd_data_q <= {2'h0, wdog_q, 4'h0};
      else if (addr_in == `CPUC_REG_MISC_CTRL)
         rd_data_q <= {force_det_q, 1'b0, sw_off_q, 5'h00};
      else if (addr_in == `CPUC_REG_SYS_STAT)
         rd_data_q <= {src_type_q, 3'h0, pg_q, 2'h0};
      else if (addr_in == `CPUC_REG_IRQ_STAT)
         rd_data_q <= {4'h0, irq_sts_q};
      else if (addr_in == `CPUC_REG_IRQ_MASK)
         rd_data_q <= {4'h0, irq_msk_q};
      else
         rd_data_q <= 8'h00;
   end

   // ----------------------------------------------------------------------
   // Output controls
   // ----------------------------------------------------------------------
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         bias_en_q  <= 1'b0;
         sw_on_q    <= 1'b0;
         load_q     <= 1'b0;
         buck_q     <= 1'b0;
         ilim_app_q <= `CPUC_ILIM_100MA;
      end
      else
      begin
         bias_en_q  <= (state_d != ST_HIZ) && (state_d != ST_DELAY);
         // Battery alone keeps the system up while the regulator is off
         sw_on_q    <= ~sw_off_q & bat_depl_s;
         load_q     <= (state_d == ST_QUAL);
         buck_q     <= (state_d == ST_GOOD);
         // Detection runs at the lowest limit
         ilim_app_q <= (state_d == ST_DETECT) ? `CPUC_ILIM_100MA : ilim_q;
      end
   end

   assign rd_data_out           = rd_data_q;
   assign bias_reg_en_out       = bias_en_q;
   assign battery_switch_on_out = sw_on_q;
   assign test_load_en_out      = load_q;
   assign buck_en_out           = buck_q;
   assign hiz_out               = ~bias_en_q;
   assign ilim_applied_out      = ilim_app_q;
   assign power_good_pin_n_out  = ~pg_q;
   assign int_out               = int_q;

endmodule // cpuc_top

// File: bench/cpuc_top_properties.sv
// Concurrent checks on the ports of the power-up control block
`timescale 1ns/1ns

module cpuc_top_properties #(
   parameter [26:0] BIAS_DLY_CYC = 27'd50
) (
   input wire       clk_in,
   input wire       rst_in,
   input wire [7:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire       wr_in,
   input wire       rd_in,
   input wire [7:0] rd_data_out,
   input wire       vbus_undervoltage_release_level_in,
   input wire       bias_reg_en_out,
   input wire       battery_switch_on_out,
   input wire       test_load_en_out,
   input wire       buck_en_out,
   input wire       hiz_out,
   input wire       power_good_pin_n_out
);
   // ----------------------------------------------------------------
   // Supply-present run length; sync lag only lengthens the real wait
   // ----------------------------------------------------------------
   logic [26:0] uv_cnt_q;
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         uv_cnt_q <= 27'h000_0000;
      else if (!vbus_undervoltage_release_level_in)
         uv_cnt_q <= 27'h000_0000;
      else
         uv_cnt_q <= uv_cnt_q + 27'h000_0001;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_bias_dly;
      $rose(bias_reg_en_out) |-> uv_cnt_q >= BIAS_DLY_CYC;
   endproperty
   a_bias_dly: assert property (p_bias_dly)
      else $error("bias regulator enabled before the delay");
   property p_hiz_low;
      $rose(bias_reg_en_out) |-> ##[0:1] !hiz_out;
   endproperty
   a_hiz_low: assert property (p_hiz_low)
      else $error("high impedance state kept with regulator on");
   property p_hiz_off;
      $rose(hiz_out) |-> ##[0:2] (!buck_en_out && !test_load_en_out);
   endproperty
   a_hiz_off: assert property (p_hiz_off)
      else $error("converter or test load active in high impedance");
   property p_sw_off;
      wr_in && addr_in == 8'h07 && wr_data_in[5] |-> ##2 !battery_switch_on_out;
   endproperty
   a_sw_off: assert property (p_sw_off)
      else $error("battery switch still on after off bit written");
   property p_buck_start;
      $rose(buck_en_out) |-> bias_reg_en_out && !power_good_pin_n_out;
   endproperty
   a_buck_start: assert property (p_buck_start)
      else $error("converter started without a qualified source");
   property p_no_early_buck;
      $rose(bias_reg_en_out) |-> !buck_en_out [*8];
   endproperty
   a_no_early_buck: assert property (p_no_early_buck)
      else $error("converter started before source test");
   property p_load_bias;
      $rose(test_load_en_out) |-> bias_reg_en_out;
   endproperty
   a_load_bias: assert property (p_load_bias)
      else $error("test load drawn with regulator off");
   property p_rd_idle;
      !$past(rd_in) |-> rd_data_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside the answer cycle");
endmodule // cpuc_top_properties

bind cpuc_top cpuc_top_properties #(.BIAS_DLY_CYC(BIAS_DLY_CYC)) u_props (
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
   .vbus_undervoltage_release_level_in(vbus_undervoltage_release_level_in), .bias_reg_en_out(bias_reg_en_out),
   .battery_switch_on_out(battery_switch_on_out), .test_load_en_out(test_load_en_out),
   .buck_en_out(buck_en_out), .hiz_out(hiz_out),
   .power_good_pin_n_out(power_good_pin_n_out));

// File: bench/cpuc_host_model.sv
// Host processor model: register access and wake pin
`timescale 1ns/1ns

module cpuc_host_model (
   input  wire        clk_in,
   input  wire  [7:0] rd_data_in,
   output logic [7:0] addr_out    = 8'h00,
   output logic [7:0] wr_data_out = 8'h00,
   output logic       wr_out      = 1'b0,
   output logic       rd_out      = 1'b0,
   output logic       wake_pin_out = 1'b0
);
   // Released bus shows inverted values so stale data cannot pass
   task wr_reg(input [7:0] a, input [7:0] d);
      @(posedge clk_in);
      addr_out    <= a;
      wr_data_out <= d;
      wr_out      <= 1'b1;
      @(posedge clk_in);
      wr_out      <= 1'b0;
      addr_out    <= ~a;
      wr_data_out <= ~d;
   endtask

   task rd_reg(input [7:0] a, output [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rd_data_in;
   endtask

   task press(input int k);
      @(posedge clk_in);
      wake_pin_out <= 1'b1;
      repeat (k) @(posedge clk_in);
      wake_pin_out <= 1'b0;
   endtask
endmodule // cpuc_host_model

// File: bench/test_charger_power_up_control.sv
// Self-checking testbench for the power-up control block
`timescale 1ns/1ns

`define CPUC_CHK(g, e) \
   begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
`define CPUC_WAIT(c) \
   begin n = 0; while (!(c) && n < 300) begin @(posedge clk_in); #1; n++; end \
   if (n >= 300) begin err_total++; $display("[FAIL] %0t wait timed out", $time); end end

module test_charger_power_up_control;
   localparam int BD = 50;
   localparam int RT = 40;
   localparam int WK = 8;
   logic clk_in = 1'b0, rst_in = 1'b1, vbus_undervoltage_release_level_in = 1'b0, sleepz = 1'b0;
   logic badsrc = 1'b0, port_type = 1'b0, cur_sel = 1'b1, wdog = 1'b0;
   logic bat_on = 1'b1, depl = 1'b1, ovp = 1'b0, boost = 1'b0, sleep = 1'b0;
   wire  [7:0] addr, wdata, rd_data;
   wire  [2:0] ilim;
   wire  wr, rd, wake, bias, sw_on, load, buck, high_impedance_state, pg_n, int_out;
   int   err_total = 0, checked = 0, n;
   logic [7:0] d;

   always #10 clk_in = ~clk_in;

   cpuc_top #(.BIAS_DLY_CYC(27'd50), .RETRY_CYC(27'd40), .BADSRC_CYC(27'd10),
      .WAKE_CYC(27'd8)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata),
      .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .vbus_undervoltage_release_level_in(vbus_undervoltage_release_level_in),
      .bat_undervoltage_release_level_in(bat_on), .bat_above_depl_in(depl), .vbus_above_sleepz_in(sleepz),
      .vbus_below_sleep_in(sleep), .boost_mode_in(boost), .vbus_ovp_in(ovp),
      .vbus_above_badsrc_in(badsrc), .port_type_pin_in(port_type),
      .current_select_pin_in(cur_sel), .wake_pin_in(wake), .wdog_expire_in(wdog),
      .bias_reg_en_out(bias), .battery_switch_on_out(sw_on), .test_load_en_out(load),
      .buck_en_out(buck), .hiz_out(high_impedance_state), .ilim_applied_out(ilim),
      .power_good_pin_n_out(pg_n), .int_out(int_out));

   cpuc_host_model u_host (
      .clk_in(clk_in), .rd_data_in(rd_data), .addr_out(addr), .wr_data_out(wdata),
      .wr_out(wr), .rd_out(rd), .wake_pin_out(wake));

   task cyc(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask

   task rchk(input [7:0] a, input [7:0] e);
      u_host.rd_reg(a, d);
      `CPUC_CHK(d, e)
   endtask

   task pulse_wdog;
      @(posedge clk_in);
      wdog <= 1'b1;
      @(posedge clk_in);
      wdog <= 1'b0;
   endtask

   task close_out;
      $display("mismatches %0d, comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Hang guard, well beyond the several hundred cycles of the sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      close_out;
   end

   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      cyc(10);
      `CPUC_CHK(sw_on, 1'b1)
      `CPUC_CHK(bias, 1'b0)
      rchk(8'h05, 8'h10);
      rchk(8'h0B, 8'h0F);
      rchk(8'h3C, 8'h00);
      @(posedge clk_in);
      depl <= 1'b0;
      cyc(4);
      `CPUC_CHK(sw_on, 1'b0)
      u_host.wr_reg(8'h05, 8'h00);
      u_host.wr_reg(8'h07, 8'h20);
      @(posedge clk_in);
      depl <= 1'b1;
      cyc(4);
      `CPUC_CHK(sw_on, 1'b0)
      rchk(8'h07, 8'h20);
      pulse_wdog;
      cyc(4);
      `CPUC_CHK(sw_on, 1'b0)
      u_host.wr_reg(8'h0B, 8'h00);
      u_host.press(3);
      cyc(6);
      `CPUC_CHK(sw_on, 1'b0)
      u_host.press(WK + 6);
      cyc(4);
      `CPUC_CHK(sw_on, 1'b1)
      `CPUC_CHK(int_out, 1'b0)
      rchk(8'h0A, 8'h08);
      u_host.wr_reg(8'h0B, 8'h0F);
      cyc(2);
      `CPUC_CHK(int_out, 1'b1)
      u_host.wr_reg(8'h0A, 8'h08);
      cyc(2);
      `CPUC_CHK(int_out, 1'b0)
      // Write zero, register reset, then watchdog expiry with field 01
      for (int e = 0; e < 3; e++)
      begin
         u_host.wr_reg(8'h07, 8'h20);
         cyc(3);
         `CPUC_CHK(sw_on, 1'b0)
         if (e == 0)
            u_host.wr_reg(8'h07, 8'h00);
         else if (e == 1)
            u_host.wr_reg(8'h01, 8'h80);
         else
            pulse_wdog;
         cyc(4);
         `CPUC_CHK(sw_on, 1'b1)
      end
      u_host.wr_reg(8'h07, 8'h20);
      @(posedge clk_in);
      vbus_undervoltage_release_level_in <= 1'b1;
      sleepz        <= 1'b1;
      port_type     <= 1'b1;
      cyc(5);
      `CPUC_CHK(sw_on, 1'b1)
      cyc(20);
      @(posedge clk_in);
      boost <= 1'b1;
      cyc(4);
      @(posedge clk_in);
      sleep <= 1'b1;
      `CPUC_WAIT(bias === 1'b1)
      `CPUC_CHK(n >= BD && n <= BD + 6, 1'b1)
      `CPUC_CHK(high_impedance_state, 1'b0)
      u_host.wr_reg(8'h0A, 8'h0F);
      `CPUC_WAIT(load === 1'b0)
      `CPUC_CHK(pg_n, 1'b1)
      `CPUC_WAIT(load === 1'b1)
      `CPUC_CHK(n >= RT - 2 && n <= RT + 4, 1'b1)
      @(posedge clk_in);
      badsrc <= 1'b1;
      ovp    <= 1'b1;
      `CPUC_WAIT(load === 1'b0)
      `CPUC_CHK(pg_n, 1'b1)
      `CPUC_WAIT(load === 1'b1)
      @(posedge clk_in);
      ovp <= 1'b0;
      u_host.wr_reg(8'h0A, 8'h0F);
      cyc(2);
      `CPUC_CHK(int_out, 1'b0)
      `CPUC_WAIT(pg_n === 1'b0)
      cyc(2);
      `CPUC_CHK(int_out, 1'b1)
      `CPUC_WAIT(buck === 1'b1)
      cyc(1);
      `CPUC_CHK(ilim, 3'h2)
      rchk(8'h08, 8'h44);
      rchk(8'h00, 8'h02);
      rchk(8'h0A, 8'h03);
      u_host.wr_reg(8'h00, 8'h03);
      cyc(2);
      `CPUC_CHK(ilim, 3'h3)
      @(posedge clk_in);
      cur_sel <= 1'b0;
      u_host.wr_reg(8'h07, 8'h80);
      cyc(40);
      `CPUC_CHK(ilim, 3'h0)
      rchk(8'h07, 8'h00);
      rchk(8'h08, 8'h44);
      u_host.wr_reg(8'h00, 8'h80);
      cyc(8);
      `CPUC_CHK(high_impedance_state, 1'b1)
      `CPUC_CHK(buck, 1'b0)
      @(posedge clk_in);
      vbus_undervoltage_release_level_in <= 1'b0;
      cyc(6);
      `CPUC_CHK(pg_n, 1'b1)
      rchk(8'h00, 8'h00);
      close_out;
   end
endmodule // test_charger_power_up_control
